// file: logic/gds_pkg.sv
// Purpose: Shared constants and types for the general device user strobes
// Assumes: Core clock of 40 MHz (25 ns period)
// Notes:   Strobe widths are derived from the nominal pulse time
package gds_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned GDS_CLK_NS = 25;
   localparam int unsigned GDS_STRB_NS = 400;
   // Least time, so round up to whole cycles
   localparam int unsigned GDS_STRB_CYC =
      (GDS_STRB_NS + GDS_CLK_NS - 1) / GDS_CLK_NS;
   localparam int unsigned GDS_CNT_W = 8;

   // ----------------------------------------------------------------
   // Widths, depths, field positions, reset values
   // ----------------------------------------------------------------
   localparam int unsigned GDS_DATA_W = 16;
   localparam int unsigned GDS_FIFO_DEPTH = 8;
   localparam int unsigned GDS_STAT_LSB = 0;
   localparam int unsigned GDS_STAT_W = 2;
   localparam int unsigned GDS_BE_LO = 0;
   localparam int unsigned GDS_BE_HI = 1;
   localparam logic [1:0] GDS_STAT_RST = 2'h0;
   localparam logic [15:0] GDS_OUT_RST = 16'h0000;
   localparam logic [15:0] GDS_IN_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Register the host cycle addresses
   typedef enum logic [1:0] {
      GDS_SEL_OUTBUF,
      GDS_SEL_INBUF,
      GDS_SEL_CSR
   } gds_sel_type;

   // Host bus request, held until acknowledged
   typedef struct packed {
      logic valid;
      logic write;
      gds_sel_type sel;
      logic [1:0] be;
      logic [15:0] wdata;
   } gds_req_type;

   // Host bus answer
   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } gds_rsp_type;

   // Queued output buffer write
   typedef struct packed {
      logic [1:0] be;
      logic [15:0] data;
   } gds_owr_type;

   typedef enum {
      GDS_ST_IDLE,
      GDS_ST_RD_PULSE,
      GDS_ST_WAIT_DROP
   } gds_host_state_type;

endpackage : gds_pkg

// file: logic/gds_top.sv
// Purpose: User side strobes, status lines and init of a 16-bit device port
// Assumes: Host holds a request until ack, then drops valid
// Notes:   Output buffer writes are queued in an 8-word FIFO
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Parameterised FIFO
// ----------------------------------------------------------------
module gds_fifo #(
   parameter int unsigned WIDTH = 18,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic push, pop;

   // Flags straight from the count
   assign in_ready_o = (cnt_reg != CNT_FULL);
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointer wrap handled explicitly, depth need not be a power of two
   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + CW'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - CW'(1);
      end
   end

   // Pointer and count registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end
endmodule : gds_fifo

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module gds_top #(
   parameter int unsigned STRB_CYC = gds_pkg::GDS_STRB_CYC,
   parameter int unsigned FIFO_DEPTH = gds_pkg::GDS_FIFO_DEPTH
) (
   // Clock and reset (reset doubles as bus initialise)
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Host bus side
   input wire gds_pkg::gds_req_type host_req_i,
   output gds_pkg::gds_rsp_type host_rsp_o,
   // User device side
   input wire logic [15:0] in_data_i,
   output logic [15:0] out_data_o,
   output logic high_byte_loaded_strobe_o,
   output logic input_taken_strobe_o,
   output logic [1:0] device_status_lines_o,
   output logic init_o
);
   import gds_pkg::*;

   localparam logic [GDS_CNT_W-1:0] STRB_LOAD = GDS_CNT_W'(STRB_CYC);
   localparam logic [GDS_CNT_W-1:0] CNT_ONE = 8'h01;

   // ----------------------------------------------------------------
   // Input pin synchroniser
   // ----------------------------------------------------------------
   logic [15:0] in_s1_reg, in_s2_reg, in_s3_reg;
   logic [15:0] in_stab_reg, in_stab_next;

   // Word accepted only once two late stages agree, so skew is filtered
   always_comb begin
      in_stab_next = in_stab_reg;
      if (in_s2_reg == in_s3_reg) begin
         in_stab_next = in_s3_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         in_s1_reg <= GDS_IN_RST;
         in_s2_reg <= GDS_IN_RST;
         in_s3_reg <= GDS_IN_RST;
         in_stab_reg <= GDS_IN_RST;
      end else begin
         in_s1_reg <= in_data_i;
         in_s2_reg <= in_s1_reg;
         in_s3_reg <= in_s2_reg;
         in_stab_reg <= in_stab_next;
      end
   end

   // ----------------------------------------------------------------
   // Output write queue
   // ----------------------------------------------------------------
   gds_owr_type push_data, pop_data;
   logic push_valid, push_ready, pop_valid, pop_ready;

   assign push_data.be = host_req_i.be;
   assign push_data.data = host_req_i.wdata;

   gds_fifo #(
      .WIDTH($bits(gds_owr_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_owr_fifo (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(push_data),
      .out_valid_o(pop_valid),
      .out_ready_i(pop_ready),
      .out_data_o(pop_data)
   );

   // ----------------------------------------------------------------
   // Host cycle handling
   // ----------------------------------------------------------------
   gds_host_state_type st_reg, st_next;
   logic ack_reg, ack_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [1:0] csr_reg, csr_next;
   logic [GDS_CNT_W-1:0] in_cnt_reg, in_cnt_next;
   logic in_strb_reg, in_strb_next;
   logic init_reg;
   logic [15:0] out_reg, out_next;

   // One request at a time; ack pulses once, then wait for valid to drop
   always_comb begin
      st_next = st_reg;
      ack_next = 1'b0;
      rdata_next = rdata_reg;
      csr_next = csr_reg;
      in_cnt_next = in_cnt_reg;
      push_valid = 1'b0;
      case (st_reg)
         GDS_ST_IDLE: begin
            if (host_req_i.valid) begin
               case (host_req_i.sel)
                  GDS_SEL_OUTBUF: begin
                     if (host_req_i.write) begin
                        // Cycle stalls here while the queue is full
                        push_valid = 1'b1;
                        if (push_ready) begin
                           ack_next = 1'b1;
                           st_next = GDS_ST_WAIT_DROP;
                        end
                     end else begin
                        rdata_next = out_reg;
                        ack_next = 1'b1;
                        st_next = GDS_ST_WAIT_DROP;
                     end
                  end
                  GDS_SEL_INBUF: begin
                     if (!host_req_i.write) begin
                        // Sampled word relies on the user holding it
                        rdata_next = in_stab_reg;
                        in_cnt_next = STRB_LOAD;
                        st_next = GDS_ST_RD_PULSE;
                     end else begin
                        ack_next = 1'b1; // Input buffer is read only
                        st_next = GDS_ST_WAIT_DROP;
                     end
                  end
                  GDS_SEL_CSR: begin
                     if (host_req_i.write && host_req_i.be[GDS_BE_LO]) begin
                        // Host loads both status bits
                        csr_next = host_req_i.wdata[GDS_STAT_LSB +: GDS_STAT_W];
                     end
                     rdata_next = {14'h0000, csr_reg};
                     ack_next = 1'b1;
                     st_next = GDS_ST_WAIT_DROP;
                  end
                  default: begin
                     rdata_next = 16'h0000;
                     ack_next = 1'b1;
                     st_next = GDS_ST_WAIT_DROP;
                  end
               endcase
            end
         end
         GDS_ST_RD_PULSE: begin
            in_cnt_next = in_cnt_reg - CNT_ONE;
            // Cycle completes only as the pulse ends
            if (in_cnt_reg == CNT_ONE) begin
               ack_next = 1'b1;
               st_next = GDS_ST_WAIT_DROP;
            end
         end
         GDS_ST_WAIT_DROP: begin
            if (!host_req_i.valid) begin
               st_next = GDS_ST_IDLE;
            end
         end
         default: begin
            st_next = GDS_ST_IDLE;
         end
      endcase
      in_strb_next = (in_cnt_next != '0);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= GDS_ST_IDLE;
         ack_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         csr_reg <= GDS_STAT_RST;
         in_cnt_reg <= '0;
         in_strb_reg <= 1'b0;
         init_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         csr_reg <= csr_next;
         in_cnt_reg <= in_cnt_next;
         in_strb_reg <= in_strb_next;
         init_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output buffer load and high-byte strobe
   // ----------------------------------------------------------------
   logic [GDS_CNT_W-1:0] hi_cnt_reg, hi_cnt_next;
   logic hi_strb_reg, hi_strb_next;

   // Drain waits for a running pulse, so the queue really fills
   assign pop_ready = (hi_cnt_reg == '0);

   always_comb begin
      out_next = out_reg;
      hi_cnt_next = hi_cnt_reg;
      if (pop_valid && pop_ready) begin
         // Data and strobe change on the same edge
         if (pop_data.be[GDS_BE_LO]) begin
            out_next[7:0] = pop_data.data[7:0];
         end
         if (pop_data.be[GDS_BE_HI]) begin
            out_next[15:8] = pop_data.data[15:8];
            hi_cnt_next = STRB_LOAD;
         end
      end else if (hi_cnt_reg != '0) begin
         hi_cnt_next = hi_cnt_reg - CNT_ONE;
      end
      hi_strb_next = (hi_cnt_next != '0);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         out_reg <= GDS_OUT_RST;
         hi_cnt_reg <= '0;
         hi_strb_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
         hi_cnt_reg <= hi_cnt_next;
         hi_strb_reg <= hi_strb_next;
      end
   end

   // Outputs, all from flops
   assign host_rsp_o.ack = ack_reg;
   assign host_rsp_o.rdata = rdata_reg;
   assign out_data_o = out_reg;
   assign high_byte_loaded_strobe_o = hi_strb_reg;
   assign input_taken_strobe_o = in_strb_reg;
   assign device_status_lines_o = csr_reg;
   assign init_o = init_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [GDS_CNT_W-1:0] in_len_reg, hi_len_reg;

   // Helper counters of pulse length
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         in_len_reg <= '0;
         hi_len_reg <= '0;
      end else begin
         in_len_reg <= in_strb_reg ? in_len_reg + CNT_ONE : '0;
         hi_len_reg <= hi_strb_reg ? hi_len_reg + CNT_ONE : '0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_HI_NEEDS_HIGH_BYTE: assert property (
      $rose(high_byte_loaded_strobe_o) |->
         $past(pop_valid && pop_ready && pop_data.be[GDS_BE_HI]))
      else $error("high byte strobe without high byte load");

   AST_RD_GIVES_STROBE: assert property (
      (st_reg == GDS_ST_IDLE && host_req_i.valid && !host_req_i.write &&
       host_req_i.sel == GDS_SEL_INBUF) |=> input_taken_strobe_o)
      else $error("input read without input-taken strobe");

   AST_IN_STRB_WIDTH: assert property (
      $fell(input_taken_strobe_o) |-> in_len_reg == STRB_LOAD)
      else $error("input-taken strobe has wrong width");

   AST_STATUS_WRITE: assert property (
      (st_reg == GDS_ST_IDLE && host_req_i.valid && host_req_i.write &&
       host_req_i.sel == GDS_SEL_CSR && host_req_i.be[GDS_BE_LO]) |=>
         device_status_lines_o == $past(host_req_i.wdata[1:0]))
      else $error("status lines do not follow written bits");

   AST_INIT_CLEARS: assert property (
      @(posedge clk_i) disable iff (1'b0)
      sys_rst_i |=> init_o && device_status_lines_o == GDS_STAT_RST &&
         out_data_o == GDS_OUT_RST && !input_taken_strobe_o)
      else $error("bus initialise did not clear state");

   AST_INIT_ONLY_IN_RESET: assert property (
      @(posedge clk_i) disable iff (1'b0)
      init_o |-> $past(sys_rst_i))
      else $error("init output without bus initialise");

   AST_LOAD_AT_LEADING_EDGE: assert property (
      $rose(high_byte_loaded_strobe_o) |->
         out_data_o[15:8] == $past(pop_data.data[15:8]))
      else $error("output high byte not loaded at strobe rise");

   AST_HI_STRB_WIDTH: assert property (
      $fell(high_byte_loaded_strobe_o) |-> hi_len_reg == STRB_LOAD)
      else $error("high byte strobe has wrong width");

   AST_ACK_AFTER_PULSE: assert property (
      $fell(input_taken_strobe_o) |-> host_rsp_o.ack ##1
         (!host_rsp_o.ack && !input_taken_strobe_o))
      else $error("read cycle not completed at pulse end");

   COV_INPUT_READ: cover property (
      $rose(input_taken_strobe_o) ##[1:300] $fell(input_taken_strobe_o));
   COV_HIGH_BYTE_WRITE: cover property ($rose(high_byte_loaded_strobe_o));
   COV_QUEUE_FULL: cover property (push_valid && !push_ready);
   COV_STATUS_SET: cover property (device_status_lines_o == 2'h3);
endmodule : gds_top

// file: verif/gds_user_model.sv
// Purpose: Far side user device model for the strobe port
// Assumes: Strobes are registered; watched on the falling clock edge
// Notes:   Counts pulse widths so the bench can compare them
`timescale 1ns/1ps

module gds_user_model (
   // Clock
   input wire logic clk_i,
   // From the port
   input wire logic [15:0] out_data_i,
   input wire logic hi_strb_i,
   input wire logic in_strb_i,
   // To the port and the bench
   output logic [15:0] in_data_o,
   output logic [15:0] cap_o,
   output int hi_n_o,
   output int hi_w_o,
   output int in_w_o,
   output logic bad_o
);
   int hw;
   int iw;

   // ----------------------------------------------------------------
   // Start values
   // ----------------------------------------------------------------
   initial begin
      in_data_o = 16'h5a3c;
      cap_o = 16'h0000;
      bad_o = 1'b0;
      hi_n_o = 0;
      hi_w_o = 0;
      in_w_o = 0;
      hw = 0;
      iw = 0;
   end

   // ----------------------------------------------------------------
   // Strobe watch
   // ----------------------------------------------------------------
   // Mid-cycle sampling keeps clear of the registered strobe edges
   always @(negedge clk_i) begin
      if (hi_strb_i) begin
         if (hw == 0) begin
            cap_o <= out_data_i;
         end else if (out_data_i !== cap_o) begin
            bad_o <= 1'b1;
         end
         hw <= hw + 1;
      end else if (hw != 0) begin
         hi_w_o <= hw;
         hi_n_o <= hi_n_o + 1;
         hw <= 0;
      end
      if (in_strb_i) begin
         iw <= iw + 1;
      end else if (iw != 0) begin
         in_w_o <= iw;
         iw <= 0;
         // Next word only once the taken pulse is over
         in_data_o <= in_data_o + 16'h1357;
      end
   end

endmodule : gds_user_model

// file: verif/test_general_device_user_strobes.sv
// Purpose: Self-checking bench for the user strobe port
// Assumes: Strobe width shortened to 8 cycles
// Notes:   Output queue is overfilled to see host back-pressure
`timescale 1ns/1ps

module test_general_device_user_strobes;
   import gds_pkg::*;

   localparam int SC = 8;

   typedef struct {
      logic w;
      logic [1:0] s;
      logic [1:0] be;
      logic [15:0] wd;
      logic [15:0] er;
      logic [1:0] es;
   } gds_row_type;

   logic clk_i;
   logic sys_rst_i;
   gds_req_type req;
   gds_rsp_type rsp;
   logic [15:0] in_d, out_d, cap, rd, exp_in;
   logic hi_s, in_s, init_o, bad;
   logic [1:0] stat;
   int hi_n, hi_w, in_w, err_total, n_tests, lat, max_lat, hn0;
   gds_row_type rows [10] = '{
      '{1'b1, 2'h2, 2'h1, 16'h0001, 16'h0000, 2'h1},
      '{1'b0, 2'h2, 2'h3, 16'h0000, 16'h0001, 2'h1},
      '{1'b1, 2'h2, 2'h2, 16'h0003, 16'h0000, 2'h1},
      '{1'b1, 2'h2, 2'h3, 16'hffff, 16'h0000, 2'h3},
      '{1'b0, 2'h2, 2'h3, 16'h0000, 16'h0003, 2'h3},
      '{1'b1, 2'h2, 2'h1, 16'h0002, 16'h0000, 2'h2},
      '{1'b0, 2'h2, 2'h3, 16'h0000, 16'h0002, 2'h2},
      '{1'b0, 2'h3, 2'h3, 16'h0000, 16'h0000, 2'h2},
      '{1'b1, 2'h1, 2'h3, 16'hffff, 16'h0000, 2'h2},
      '{1'b0, 2'h0, 2'h3, 16'h0000, 16'h0000, 2'h2}};

   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   gds_top #(.STRB_CYC(SC), .FIFO_DEPTH(8)) uut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .host_req_i(req), .host_rsp_o(rsp),
      .in_data_i(in_d), .out_data_o(out_d),
      .high_byte_loaded_strobe_o(hi_s), .input_taken_strobe_o(in_s),
      .device_status_lines_o(stat), .init_o(init_o));

   gds_user_model user_dev (
      .clk_i(clk_i), .out_data_i(out_d), .hi_strb_i(hi_s),
      .in_strb_i(in_s), .in_data_o(in_d), .cap_o(cap),
      .hi_n_o(hi_n), .hi_w_o(hi_w), .in_w_o(in_w), .bad_o(bad));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp,
                        input string what);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // Request held until ack is seen, then dropped
   task automatic host(input logic w, input logic [1:0] s,
                       input logic [1:0] be, input logic [15:0] wd);
      @(posedge clk_i);
      #1;
      req.valid = 1'b1;
      req.write = w;
      req.sel = gds_sel_type'(s);
      req.be = be;
      req.wdata = wd;
      lat = 0;
      do begin
         @(posedge clk_i);
         #1;
         lat++;
      end while (rsp.ack !== 1'b1);
      rd = rsp.rdata;
      req.valid = 1'b0;
   endtask : host

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : settle

   task automatic report_and_stop;
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Whole run is under 1500 cycles; allow ample margin
   initial begin
      #(25 * 6000);
      err_total++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      req = '0;
      sys_rst_i = 1'b1;
      err_total = 0;
      n_tests = 0;
      settle(12);
      check({15'h0, init_o}, 16'h1, "init in reset");
      check({14'h0, stat}, 16'h0, "status in reset");
      sys_rst_i = 1'b0;
      settle(1);
      check({15'h0, init_o}, 16'h0, "init after reset");
      // Status register table
      for (int i = 0; i < 10; i++) begin
         host(rows[i].w, rows[i].s, rows[i].be, rows[i].wd);
         check(16'(lat), 16'h1, "ack time");
         if (!rows[i].w) begin
            check(rd, rows[i].er, "read data");
         end
         check({14'h0, stat}, {14'h0, rows[i].es}, "status");
      end
      // Input buffer reads, stretched cycle and taken pulse
      exp_in = 16'h5a3c;
      for (int k = 0; k < 2; k++) begin
         settle(6);
         host(1'b0, 2'h1, 2'h3, 16'h0000);
         check(rd, exp_in, "input word");
         check(16'(lat), 16'(SC + 1), "read stretch");
         @(negedge clk_i);
         #1;
         check(16'(in_w), 16'(SC), "taken width");
         exp_in = exp_in + 16'h1357;
      end
      // Output buffer byte loads
      hn0 = hi_n;
      host(1'b1, 2'h0, 2'h3, 16'habcd);
      settle(SC + 4);
      check(out_d, 16'habcd, "out word");
      check(cap, 16'habcd, "leading edge");
      check(16'(hi_n - hn0), 16'h1, "high strobe");
      check(16'(hi_w), 16'(SC), "high width");
      host(1'b1, 2'h0, 2'h1, 16'h0012);
      settle(SC + 4);
      check(out_d, 16'hab12, "low byte");
      check(16'(hi_n - hn0), 16'h1, "no low strobe");
      host(1'b1, 2'h0, 2'h2, 16'h3400);
      settle(SC + 4);
      check(cap, 16'h3412, "high byte");
      check(16'(hi_n - hn0), 16'h2, "high strobe 2");
      // Overfill the queue while strobes hold it back
      hn0 = hi_n;
      max_lat = 0;
      for (int i = 0; i < 16; i++) begin
         host(1'b1, 2'h0, 2'h3, 16'h1000 + 16'(i));
         if (lat > max_lat) max_lat = lat;
      end
      check(16'(max_lat > 1), 16'h1, "no back-pressure");
      settle(16 * (SC + 3));
      check(16'(hi_n - hn0), 16'd16, "strobe count");
      check(cap, 16'h100f, "last word");
      check({15'h0, bad}, 16'h0, "data moved in pulse");
      // Bus initialise in mid-run
      host(1'b1, 2'h2, 2'h3, 16'h0003);
      settle(1);
      sys_rst_i = 1'b1;
      settle(2);
      check({15'h0, init_o}, 16'h1, "init again");
      check({14'h0, stat}, 16'h0, "status cleared");
      check(out_d, 16'h0000, "out cleared");
      sys_rst_i = 1'b0;
      settle(1);
      check({15'h0, init_o}, 16'h0, "init released");
      report_and_stop();
   end

endmodule : test_general_device_user_strobes
